/* File: common/scg_pkg.sv */
package scg_pkg;
   // Register byte addresses
   localparam logic [31:0] SCG_ADDR_LF_CTRL    = 32'h5000_0000;
   localparam logic [31:0] SCG_ADDR_SYS_CTRL   = 32'h5000_0004;
   localparam logic [31:0] SCG_ADDR_RESET_CTRL = 32'h5000_0008;

   // Low frequency clock control fields
   localparam int SCG_LF_SEL_BIT    = 8;
   localparam int SCG_LF_STATUS_BIT = 0;
   localparam logic SCG_LF_SEL_RST  = 1'h1;

   // System clock control fields
   localparam int SCG_VSEL_LSB      = 20;
   localparam int SCG_VSEL_W        = 2;
   localparam int SCG_DIV_LSB       = 16;
   localparam int SCG_DIV_W         = 3;
   localparam int SCG_MUX_SEL_BIT   = 8;
   localparam int SCG_FAST_STS_BIT  = 1;
   localparam int SCG_FAST_EN_BIT   = 0;
   localparam logic [1:0] SCG_VSEL_RST = 2'h1;
   localparam logic [2:0] SCG_DIV_RST  = 3'h0;
   localparam logic SCG_MUX_SEL_RST    = 1'h0;
   localparam logic SCG_FAST_EN_RST    = 1'h0;

   // Byte lanes holding each field
   localparam int SCG_LANE_B0 = 0;
   localparam int SCG_LANE_B1 = 1;
   localparam int SCG_LANE_B2 = 2;

   // Nominal oscillator rates in kHz
   localparam int SCG_FAST_OSC_KHZ = 16000;
   localparam int SCG_LF_OSC_KHZ   = 256;

   // Half periods of source per half period of output
   localparam int SCG_DIV_CW           = 5;
   localparam logic [4:0] SCG_LF_HALF2  = 5'h02;
   localparam logic [4:0] SCG_LF_HALF16 = 5'h10;

   // AXI responses
   localparam logic [1:0] SCG_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       lf_sel;
      logic [1:0] vsel;
      logic [2:0] div;
      logic       mux_sel;
      logic       fast_en;
   } scg_cfg_s;
endpackage

/* File: core/scg_clk_div.sv */
`timescale 1ns/1ps
module scg_clk_div
   import scg_pkg::*;
#(
   parameter int         CW       = SCG_DIV_CW,
   parameter logic [4:0] RST_HALF = SCG_LF_HALF2
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Source half-period events and ratio
   input  wire logic          src_edge,
   input  wire logic [CW-1:0] half_count,
   // Divided clock level
   output logic               clk_out
);
   logic [CW-1:0] cnt_ff,   nxt_cnt;
   logic [CW-1:0] ratio_ff, nxt_ratio;
   logic          clk_ff,   nxt_clk;

   // Ratio reloads only at a toggle, so no short half period
   always_comb begin
      nxt_cnt   = cnt_ff;
      nxt_ratio = ratio_ff;
      nxt_clk   = clk_ff;
      if (src_edge) begin
         if (CW'(cnt_ff + 1'b1) >= ratio_ff) begin
            nxt_cnt   = '0;
            nxt_clk   = ~clk_ff;
            nxt_ratio = half_count;
         end else begin
            nxt_cnt = CW'(cnt_ff + 1'b1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff   <= '0;
         ratio_ff <= CW'(RST_HALF);
         clk_ff   <= 1'b0;
      end else begin
         cnt_ff   <= nxt_cnt;
         ratio_ff <= nxt_ratio;
         clk_ff   <= nxt_clk;
      end
   end

   assign clk_out = clk_ff;
endmodule // scg_clk_div

/* File: core/scg_glitch_mux.sv */
`timescale 1ns/1ps
module scg_glitch_mux
   import scg_pkg::*;
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Sources and select
   input  wire logic src_slow,
   input  wire logic src_fast,
   input  wire logic sel,
   // Muxed clock and active source
   output logic      clk_out,
   output logic      cur_sel
);
   logic cur_ff, nxt_cur;
   logic out_ff, nxt_out;

   // Switch only while both sources and the output are low, so no short high
   always_comb begin
      nxt_cur = cur_ff;
      if ((sel != cur_ff) && !src_slow && !src_fast && !out_ff) begin
         nxt_cur = sel;
      end
      nxt_out = nxt_cur ? src_fast : src_slow;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur_ff <= SCG_MUX_SEL_RST;
         out_ff <= 1'b0;
      end else begin
         cur_ff <= nxt_cur;
         out_ff <= nxt_out;
      end
   end

   assign clk_out = out_ff;
   assign cur_sel = cur_ff;
endmodule // scg_glitch_mux

/* File: core/scg_top.sv */
`timescale 1ns/1ps
module scg_top
   import scg_pkg::*;
#(
   parameter int FAST_OSC_KHZ = SCG_FAST_OSC_KHZ,
   parameter int LF_OSC_KHZ   = SCG_LF_OSC_KHZ
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Oscillator pins
   input  wire logic        low_frequency_osc_output,
   input  wire logic        fast_osc_clock,
   // Power management
   input  wire logic        pmu_fast_osc_start,
   input  wire logic        sleep_entry,
   input  wire logic        deep_sleep_mode,
   // Oscillator control
   output logic             fast_osc_enable,
   output logic [1:0]       fast_osc_regulator_voltage,
   // System clock
   output logic             system_clock,
   output logic             slow_osc_status,
   output logic             fast_osc_status
);
   // Configuration registers
   scg_cfg_s    cfg_ff, nxt_cfg;
   // Status registers
   logic        lf_sts_ff, nxt_lf_sts;
   logic        fast_sts_ff, nxt_fast_sts;
   logic        fast_en_out_ff, nxt_fast_en_out;
   logic [1:0]  vsel_out_ff, nxt_vsel_out;
   logic        sysclk_ff, nxt_sysclk;
   // Pin synchronisers
   logic        lf_s1_ff, lf_s2_ff, lf_s3_ff;
   logic        fast_s1_ff, fast_s2_ff, fast_s3_ff;
   // Write channel state
   logic        aw_hold_ff, nxt_aw_hold;
   logic        w_hold_ff, nxt_w_hold;
   logic [31:0] awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0]  wstrb_ff, nxt_wstrb;
   logic        awready_ff, nxt_awready;
   logic        wready_ff, nxt_wready;
   logic        bvalid_ff, nxt_bvalid;
   logic [1:0]  bresp_ff, nxt_bresp;
   // Read channel state
   logic        arready_ff, nxt_arready;
   logic        rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0]  rresp_ff, nxt_rresp;
   // Internal nets
   logic        lf_edge, fast_edge;
   logic        slow_clk, fast_div_clk;
   logic        mux_clk, mux_cur;
   logic        mux_req;
   logic        do_write;
   logic [4:0]  lf_half, fast_half;

   function automatic logic addr_mapped(input logic [31:0] a);
      addr_mapped = (a == SCG_ADDR_LF_CTRL) || (a == SCG_ADDR_SYS_CTRL) ||
                    (a == SCG_ADDR_RESET_CTRL);
   endfunction

   // Two-stage synchronisers, third stage for change detect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lf_s1_ff   <= 1'b0;
         lf_s2_ff   <= 1'b0;
         lf_s3_ff   <= 1'b0;
         fast_s1_ff <= 1'b0;
         fast_s2_ff <= 1'b0;
         fast_s3_ff <= 1'b0;
      end else begin
         lf_s1_ff   <= low_frequency_osc_output;
         lf_s2_ff   <= lf_s1_ff;
         lf_s3_ff   <= lf_s2_ff;
         fast_s1_ff <= fast_osc_clock;
         fast_s2_ff <= fast_s1_ff;
         fast_s3_ff <= fast_s2_ff;
      end
   end

   assign lf_edge   = lf_s2_ff ^ lf_s3_ff;
   assign fast_edge = fast_s2_ff ^ fast_s3_ff;

   assign lf_half   = cfg_ff.lf_sel ? SCG_LF_HALF16 : SCG_LF_HALF2;
   // fast ratio is field plus one
   assign fast_half = 5'({2'h0, cfg_ff.div} + 5'h01);

   // slow clock from the low-frequency source
   scg_clk_div #(
      .CW       (SCG_DIV_CW),
      .RST_HALF (SCG_LF_HALF16)
   ) u_slow_div (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .src_edge   (lf_edge),
      .half_count (lf_half),
      .clk_out    (slow_clk)
   );

   scg_clk_div #(
      .CW       (SCG_DIV_CW),
      .RST_HALF (5'h01)
   ) u_fast_div (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .src_edge   (fast_edge),
      .half_count (fast_half),
      .clk_out    (fast_div_clk)
   );

   // deep sleep forces the slow source
   assign mux_req = cfg_ff.mux_sel & ~deep_sleep_mode;

   scg_glitch_mux u_mux (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .src_slow (slow_clk),
      .src_fast (fast_div_clk),
      .sel      (mux_req),
      .clk_out  (mux_clk),
      .cur_sel  (mux_cur)
   );

   // Write performed once address and data are both held
   assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;

   // AXI write channels
   always_comb begin
      nxt_aw_hold = aw_hold_ff;
      nxt_w_hold  = w_hold_ff;
      nxt_awaddr  = awaddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_hold = 1'b1;
         nxt_awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_hold = 1'b1;
         nxt_wdata  = s_axi_wdata;
         nxt_wstrb  = s_axi_wstrb;
      end
      if (do_write) begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = addr_mapped(awaddr_ff) ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      nxt_awready = !nxt_aw_hold && !nxt_bvalid;
      nxt_wready  = !nxt_w_hold && !nxt_bvalid;
   end

   // Configuration writes and hardware updates
   always_comb begin
      nxt_cfg = cfg_ff;
      if (do_write && (awaddr_ff == SCG_ADDR_LF_CTRL) && wstrb_ff[SCG_LANE_B1]) begin
         nxt_cfg.lf_sel = wdata_ff[SCG_LF_SEL_BIT];
      end
      if (do_write && (awaddr_ff == SCG_ADDR_SYS_CTRL)) begin
         if (wstrb_ff[SCG_LANE_B2]) begin
            nxt_cfg.vsel = wdata_ff[SCG_VSEL_LSB +: SCG_VSEL_W];
            nxt_cfg.div  = wdata_ff[SCG_DIV_LSB +: SCG_DIV_W];
         end
         if (wstrb_ff[SCG_LANE_B1]) begin
            nxt_cfg.mux_sel = wdata_ff[SCG_MUX_SEL_BIT];
         end
         if (wstrb_ff[SCG_LANE_B0]) begin
            nxt_cfg.fast_en = wdata_ff[SCG_FAST_EN_BIT];
         end
      end
      if (sleep_entry) begin
         nxt_cfg.fast_en = 1'b0;
      end
   end

   // Status and pin outputs
   always_comb begin
      nxt_lf_sts      = ~mux_cur;
      // enabled by software or power management
      nxt_fast_en_out = nxt_cfg.fast_en | pmu_fast_osc_start;
      nxt_fast_sts    = fast_en_out_ff;
      nxt_vsel_out    = cfg_ff.vsel;
      nxt_sysclk      = mux_clk;
   end

   // AXI read channels
   always_comb begin
      // Ready returns after reset and once no read is pending
      nxt_arready = arready_ff || !rvalid_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      if (s_axi_arvalid && arready_ff) begin
         nxt_arready = 1'b0;
         nxt_rvalid  = 1'b1;
         nxt_rdata   = '0;
         nxt_rresp   = addr_mapped(s_axi_araddr) ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
         if (s_axi_araddr == SCG_ADDR_LF_CTRL) begin
            nxt_rdata[SCG_LF_SEL_BIT]    = cfg_ff.lf_sel;
            nxt_rdata[SCG_LF_STATUS_BIT] = lf_sts_ff;
         end
         if (s_axi_araddr == SCG_ADDR_SYS_CTRL) begin
            nxt_rdata[SCG_VSEL_LSB +: SCG_VSEL_W] = cfg_ff.vsel;
            nxt_rdata[SCG_DIV_LSB +: SCG_DIV_W]   = cfg_ff.div;
            nxt_rdata[SCG_MUX_SEL_BIT]            = cfg_ff.mux_sel;
            nxt_rdata[SCG_FAST_STS_BIT]           = fast_sts_ff;
            nxt_rdata[SCG_FAST_EN_BIT]            = cfg_ff.fast_en;
         end
      end
      if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid  = 1'b0;
         nxt_arready = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff.lf_sel   <= SCG_LF_SEL_RST;
         cfg_ff.vsel     <= SCG_VSEL_RST;
         cfg_ff.div      <= SCG_DIV_RST;
         cfg_ff.mux_sel  <= SCG_MUX_SEL_RST;
         cfg_ff.fast_en  <= SCG_FAST_EN_RST;
         lf_sts_ff       <= 1'b0;
         fast_sts_ff     <= 1'b0;
         fast_en_out_ff  <= 1'b0;
         vsel_out_ff     <= SCG_VSEL_RST;
         sysclk_ff       <= 1'b0;
      end else begin
         cfg_ff          <= nxt_cfg;
         lf_sts_ff       <= nxt_lf_sts;
         fast_sts_ff     <= nxt_fast_sts;
         fast_en_out_ff  <= nxt_fast_en_out;
         vsel_out_ff     <= nxt_vsel_out;
         sysclk_ff       <= nxt_sysclk;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= SCG_RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= SCG_RESP_OKAY;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         w_hold_ff  <= nxt_w_hold;
         awaddr_ff  <= nxt_awaddr;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end
   end

   assign s_axi_awready              = awready_ff;
   assign s_axi_wready               = wready_ff;
   assign s_axi_bvalid               = bvalid_ff;
   assign s_axi_bresp                = bresp_ff;
   assign s_axi_arready              = arready_ff;
   assign s_axi_rvalid               = rvalid_ff;
   assign s_axi_rdata                = rdata_ff;
   assign s_axi_rresp                = rresp_ff;
   assign fast_osc_enable            = fast_en_out_ff;
   assign fast_osc_regulator_voltage = vsel_out_ff;
   assign system_clock               = sysclk_ff;
   assign slow_osc_status            = lf_sts_ff;
   assign fast_osc_status            = fast_sts_ff;
endmodule // scg_top

/* File: tb/scg_top_sva.sv */
`timescale 1ns/1ps
module scg_top_sva
   import scg_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Power and clock
   input wire logic        pmu_fast_osc_start,
   input wire logic        sleep_entry,
   input wire logic        deep_sleep_mode,
   input wire logic        fast_osc_enable,
   input wire logic        system_clock,
   input wire logic        slow_osc_status,
   input wire logic        fast_osc_status
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [31:0] ar_ff, nxt_ar_ff;
   logic [8:0]  deep_ff, nxt_deep_ff;
   logic        ar_bad;

   assign ar_bad = !(ar_ff inside {SCG_ADDR_LF_CTRL, SCG_ADDR_SYS_CTRL, SCG_ADDR_RESET_CTRL});

   always_comb begin
      nxt_ar_ff   = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_ff;
      nxt_deep_ff = !deep_sleep_mode ? 9'h000 : (deep_ff == 9'h1FF) ? deep_ff : deep_ff + 9'h001;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_ff   <= 32'h0;
         deep_ff <= 9'h000;
      end else begin
         ar_ff   <= nxt_ar_ff;
         deep_ff <= nxt_deep_ff;
      end
   end

   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_sleep;
      sleep_entry && !pmu_fast_osc_start ##1 !pmu_fast_osc_start;
   endsequence

   aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready stayed high after address taken");
   wr_resp_a: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   unmap_rd_a: assert property (s_axi_rvalid && ar_bad |-> s_axi_rresp == SCG_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   fast_sts_a: assert property ($changed(fast_osc_enable) |=> fast_osc_status == $past(fast_osc_enable))
      else $error("fast status does not follow enable");
   pmu_start_a: assert property (pmu_fast_osc_start |-> ##[1:2] fast_osc_enable)
      else $error("power management start ignored");
   sleep_clr_a: assert property (s_sleep |=> !fast_osc_enable)
      else $error("sleep did not clear fast enable");
   deep_slow_a: assert property (deep_ff >= 9'd400 |-> slow_osc_status)
      else $error("slow source not active in deep sleep");
   no_runt_a: assert property ($changed(system_clock) |=> $stable(system_clock))
      else $error("runt pulse on system clock");
endmodule // scg_top_sva

bind scg_top scg_top_sva u_sva (.*);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb
   import scg_pkg::*;
;
   localparam int LF_HALF = 10;
   localparam int FO_HALF = 2;

   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        low_frequency_osc_output, fast_osc_clock, pmu_fast_osc_start, sleep_entry, deep_sleep_mode;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  r;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic   fast_osc_enable, system_clock, slow_osc_status, fast_osc_status;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp, fast_osc_regulator_voltage;
   wire logic [31:0] s_axi_rdata;
   int          num_errors, num_checks, cyc;
   scg_cfg_s    c;

   scg_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_frequency_osc_output,
      .fast_osc_clock, .pmu_fast_osc_start, .sleep_entry, .deep_sleep_mode, .fast_osc_enable,
      .fast_osc_regulator_voltage, .system_clock, .slow_osc_status, .fast_osc_status);

   always #50 aclk = ~aclk;
   initial begin
      low_frequency_osc_output = 0;
      #337;
      forever #1000 low_frequency_osc_output = ~low_frequency_osc_output;
   end
   initial begin
      fast_osc_clock = 0;
      #23;
      forever #200 fast_osc_clock = ~fast_osc_clock;
   end

   function automatic logic [31:0] exp_sys(scg_cfg_s x);
      return {10'h0, x.vsel, 1'b0, x.div, 7'h0, x.mux_sel, 6'h0, x.fast_en, x.fast_en};
   endfunction
   function automatic int exp_per(scg_cfg_s x);
      return x.mux_sel ? (int'(x.div) + 1) * 2 * FO_HALF : (x.lf_sel ? 16 : 2) * 2 * LF_HALF;
   endfunction

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] dt, input logic [3:0] s);
      logic ad, wd;
      ad = 0;
      wd = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= dt;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid  <= 1;
      s_axi_bready  <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd = 1;
            s_axi_wvalid <= 0;
         end
      end while (!(s_axi_bvalid && ad && wd));
      r = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [31:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1;
      s_axi_rready  <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask

   // Second full period, after any switch or ratio change has settled
   task automatic per(input int exp);
      time t0;
      int  n;
      wait (slow_osc_status == !c.mux_sel);
      repeat (2) @(posedge system_clock);
      t0 = $time;
      @(posedge system_clock);
      n = int'(($time - t0) / 100);
      num_checks++;
      if (n < exp - 1 || n > exp + 1) begin
         num_errors++;
         $display("MISMATCH t=%0t period %0d exp %0d", $time, n, exp);
      end
      @(posedge aclk);
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         close_out;
      end
   end

   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
      {pmu_fast_osc_start, sleep_entry, deep_sleep_mode} = 3'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
      num_errors = 0;
      num_checks = 0;
      d = $urandom(32'hEBBE);
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      repeat (3) @(posedge aclk);
      c = '{lf_sel: SCG_LF_SEL_RST, vsel: SCG_VSEL_RST, div: SCG_DIV_RST, mux_sel: 1'b0, fast_en: 1'b0};
      rd(SCG_ADDR_LF_CTRL);
      chk(d, 32'h0000_0101);
      rd(SCG_ADDR_SYS_CTRL);
      chk(d, exp_sys(c));
      chk(fast_osc_regulator_voltage, SCG_VSEL_RST);
      rd(SCG_ADDR_RESET_CTRL);
      chk(d, 32'h0);
      chk(32'(r), 32'(SCG_RESP_OKAY));
      rd(32'h5000_000C);
      chk(d, 32'h0);
      chk(32'(r), 32'(SCG_RESP_SLVERR));
      wr(32'h5000_000C, 32'hFFFF_FFFF, 4'hF);
      chk(r, SCG_RESP_SLVERR);
      per(exp_per(c));
      wr(SCG_ADDR_LF_CTRL, 32'h0, 4'hF);
      c.lf_sel = 0;
      rd(SCG_ADDR_LF_CTRL);
      chk(d, 32'h0000_0001);
      per(exp_per(c));
      repeat (3) begin
         {c.vsel, c.div} = 5'($urandom);
         c.fast_en = 1;
         wr(SCG_ADDR_SYS_CTRL, exp_sys(c), 4'hF);
         rd(SCG_ADDR_SYS_CTRL);
         chk(d, exp_sys(c));
         chk({fast_osc_regulator_voltage, fast_osc_enable}, {c.vsel, 1'b1});
      end
      wr(SCG_ADDR_SYS_CTRL, 32'hFFFF_FFFF, 4'h4);
      c.vsel = 2'h3;
      c.div = 3'h7;
      rd(SCG_ADDR_SYS_CTRL);
      chk(d, exp_sys(c));
      chk(d[SCG_FAST_STS_BIT], 1'b1);
      for (int i = 0; i < 3; i++) begin
         c.div = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom);
         c.mux_sel = 1;
         wr(SCG_ADDR_SYS_CTRL, exp_sys(c), 4'hF);
         per(exp_per(c));
         chk(slow_osc_status, 1'b0);
      end
      wr(SCG_ADDR_LF_CTRL, 32'h0000_0100, 4'h2);
      c.lf_sel = 1;
      deep_sleep_mode <= 1;
      c.mux_sel = 0;
      per(exp_per(c));
      chk(slow_osc_status, 1'b1);
      rd(SCG_ADDR_LF_CTRL);
      chk(d, 32'h0000_0101);
      deep_sleep_mode <= 0;
      wr(SCG_ADDR_SYS_CTRL, exp_sys(c), 4'hF);
      sleep_entry <= 1;
      @(posedge aclk);
      sleep_entry <= 0;
      repeat (2) @(posedge aclk);
      c.fast_en = 0;
      rd(SCG_ADDR_SYS_CTRL);
      chk(d, exp_sys(c));
      chk(fast_osc_enable, 1'b0);
      pmu_fast_osc_start <= 1;
      repeat (2) @(posedge aclk);
      rd(SCG_ADDR_SYS_CTRL);
      chk({fast_osc_enable, d[SCG_FAST_STS_BIT]}, 2'h3);
      pmu_fast_osc_start <= 0;
      repeat (3) @(posedge aclk);
      chk(fast_osc_status, 1'b0);
      close_out;
   end
endmodule // tb
